// ==== design/pcg_pkg.sv ====
// Package of offsets, field layouts, reset values and modes for the clock gating block.
package pcg_pkg;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [11:0] PCG_RUN_CFG_OFF = 12'h060;
  localparam logic [11:0] PCG_RUN_GATE_OFF = 12'h100;
  localparam logic [11:0] PCG_SLP_GATE_OFF = 12'h110;
  localparam logic [11:0] PCG_DSLP_GATE_OFF = 12'h120;
  localparam logic [11:0] PCG_INT_STAT_OFF = 12'h130;
  localparam logic [11:0] PCG_INT_MASK_OFF = 12'h134;

  // ==========================================================================
  // Bit positions of the gating fields.
  localparam int PCG_WDT_BIT = 3;
  localparam int PCG_HIB_BIT = 6;
  localparam int PCG_RATE_LSB = 8;
  localparam int PCG_ADC_BIT = 16;
  localparam int PCG_PWM_BIT = 20;
  localparam int PCG_AUTO_GATE_BIT = 0;

  // Unit index order in every per-unit vector.
  localparam int PCG_UNITS = 4;
  localparam int PCG_U_WDT = 0;
  localparam int PCG_U_HIB = 1;
  localparam int PCG_U_ADC = 2;
  localparam int PCG_U_PWM = 3;

  // ==========================================================================
  // Reset values and writable masks.
  localparam logic [31:0] PCG_GATE_RST = 32'h0000_0040;
  localparam logic [31:0] PCG_RUN_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] PCG_RUN_SLP_MASK = 32'h0011_0348;
  localparam logic [31:0] PCG_DSLP_MASK = 32'h0011_0048;
  localparam logic [31:0] PCG_RUN_CFG_MASK = 32'h0000_0001;
  localparam logic [3:0] PCG_INT_RST = 4'h0;
  localparam logic [1:0] PCG_RATE_MAX_DEF = 2'h3;

  // ==========================================================================
  // Power modes, Gray coded along run, sleep, deep sleep.
  typedef enum logic [1:0] {
    PCG_MODE_RUN = 2'b00,
    PCG_MODE_SLEEP = 2'b01,
    PCG_MODE_DEEP = 2'b11
  } pcg_mode_t;

  // AHB transfer types used by the slave.
  localparam logic [1:0] PCG_HTRANS_NONSEQ = 2'b10;

endpackage : pcg_pkg

// ==== design/pcg_gate_sel.sv ====
// Selector of the active gating set for the present power mode.
`timescale 1ns/1ps
module pcg_gate_sel #(
  parameter int WIDTH = 4
) (
  input wire logic [1:0] power_mode,
  input wire logic auto_gate,
  input wire logic [WIDTH-1:0] run_gate,
  input wire logic [WIDTH-1:0] sleep_gate,
  input wire logic [WIDTH-1:0] deep_gate,
  output logic [WIDTH-1:0] gate_out,
  output logic use_deep
);

  // ==========================================================================
  // Mode selection.
  // Without automatic gating the run set stays in force in every mode.
  wire logic in_sleep;
  wire logic in_deep;
  assign in_sleep = auto_gate && (power_mode == pcg_pkg::PCG_MODE_SLEEP);
  assign in_deep = auto_gate && (power_mode == pcg_pkg::PCG_MODE_DEEP);
  assign use_deep = in_deep;

  // Pick the set whose mode matches; unknown codes fall back to the run set.
  always_comb begin
    case ({in_deep, in_sleep})
      2'b01: gate_out = sleep_gate;
      2'b10: gate_out = deep_gate;
      default: gate_out = run_gate;
    endcase
  end

endmodule : pcg_gate_sel

// ==== design/pcg_ctrl.sv ====
// Peripheral clock gating controller with its AHB-Lite register slave.
//
// Function
// - A set gating bit clocks its unit and a clear one stops that unit's clock.
// - An access to a unit whose gate is clear is answered with a bus fault.
// - Gating bits reset to zero unless a different reset value is given.
// - The hibernation gate at bit 6 is read/write and resets to one.
// - The watchdog gate at bit 3 is read/write, resets to zero and faults accesses when clear.
// - Bits 9:8 select the converter rate: 125K, 250K, 500K or 1M samples per second.
// - The applied converter rate never exceeds the highest rate the part supports.
// - Separate gating sets exist for run, sleep and deep-sleep operation.
// - The sleep and deep-sleep sets apply only while the automatic gating bit is set.
// - The deep-sleep gating register sits at 0x120 and resets to 0x00000040.
// - Reserved bits are read-only and read as zero.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module pcg_ctrl #(
  parameter logic [1:0] RATE_MAX = pcg_pkg::PCG_RATE_MAX_DEF
) (
  input wire logic mclk,
  input wire logic resetn,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Power mode from the mode controller, same clock.
  input wire logic [1:0] power_mode,
  // Per-unit access strobes from the peripheral fabric, same clock.
  input wire logic [3:0] unit_access,
  output logic [3:0] unit_fault,
  output logic [3:0] unit_clk_en,
  output logic [1:0] converter_rate,
  output logic irq
);

  // ==========================================================================
  // Register state.
  logic [31:0] run_gating_reg;
  logic [31:0] sleep_gating_reg;
  logic [31:0] deep_sleep_gating_reg;
  logic [31:0] run_clock_config_reg;
  logic [3:0] int_stat_reg;
  logic [3:0] int_mask_reg;
  logic [31:0] run_gating_next;
  logic [31:0] sleep_gating_next;
  logic [31:0] deep_sleep_gating_next;
  logic [31:0] run_clock_config_next;
  logic [3:0] int_stat_next;
  logic [3:0] int_mask_next;
  logic wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic [31:0] rdata_reg;
  logic [3:0] clk_en_reg;
  logic [3:0] fault_reg;
  logic [1:0] rate_reg;

  // ==========================================================================
  // Bus decode.
  // The slave never inserts wait states, so hreadyout is constant high.
  wire logic addr_phase;
  wire logic wr_start;
  wire logic rd_start;
  assign addr_phase = hsel && hready && (htrans == pcg_pkg::PCG_HTRANS_NONSEQ);
  assign wr_start = addr_phase && hwrite;
  assign rd_start = addr_phase && !hwrite;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  // Write strobes decoded from the captured address during the data phase.
  wire logic wr_run_cfg;
  wire logic wr_run;
  wire logic wr_slp;
  wire logic wr_dslp;
  wire logic wr_stat;
  wire logic wr_mask;
  assign wr_run_cfg = wr_pend_reg && (wr_addr_reg == pcg_pkg::PCG_RUN_CFG_OFF);
  assign wr_run = wr_pend_reg && (wr_addr_reg == pcg_pkg::PCG_RUN_GATE_OFF);
  assign wr_slp = wr_pend_reg && (wr_addr_reg == pcg_pkg::PCG_SLP_GATE_OFF);
  assign wr_dslp = wr_pend_reg && (wr_addr_reg == pcg_pkg::PCG_DSLP_GATE_OFF);
  assign wr_stat = wr_pend_reg && (wr_addr_reg == pcg_pkg::PCG_INT_STAT_OFF);
  assign wr_mask = wr_pend_reg && (wr_addr_reg == pcg_pkg::PCG_INT_MASK_OFF);

  // ==========================================================================
  // Next register values.
  // Masks keep reserved bits at zero whatever software writes.
  assign run_gating_next = wr_run ? (hwdata & pcg_pkg::PCG_RUN_SLP_MASK)
                                  : run_gating_reg;
  assign sleep_gating_next = wr_slp ? (hwdata & pcg_pkg::PCG_RUN_SLP_MASK)
                                    : sleep_gating_reg;
  assign deep_sleep_gating_next = wr_dslp ? (hwdata & pcg_pkg::PCG_DSLP_MASK)
                                          : deep_sleep_gating_reg;
  assign run_clock_config_next = wr_run_cfg ? (hwdata & pcg_pkg::PCG_RUN_CFG_MASK)
                                            : run_clock_config_reg;
  assign int_mask_next = wr_mask ? hwdata[3:0] : int_mask_reg;

  // A fault raised in the cycle that software clears its bit stays set.
  assign int_stat_next = (int_stat_reg & ~(wr_stat ? hwdata[3:0] : 4'h0)) | fault_reg;

  // ==========================================================================
  // Read mux on next values, so a read straight after a write sees the new data.
  wire logic [31:0] rd_mux;
  assign rd_mux =
    (haddr == pcg_pkg::PCG_RUN_CFG_OFF) ? run_clock_config_next :
    (haddr == pcg_pkg::PCG_RUN_GATE_OFF) ? run_gating_next :
    (haddr == pcg_pkg::PCG_SLP_GATE_OFF) ? sleep_gating_next :
    (haddr == pcg_pkg::PCG_DSLP_GATE_OFF) ? deep_sleep_gating_next :
    (haddr == pcg_pkg::PCG_INT_STAT_OFF) ? {28'h0000000, int_stat_next} :
    (haddr == pcg_pkg::PCG_INT_MASK_OFF) ? {28'h0000000, int_mask_next} :
    32'h0000_0000;

  // ==========================================================================
  // Per-unit views of each gating set.
  function automatic logic [3:0] unit_bits(input logic [31:0] r);
    logic [3:0] v;
    v = 4'h0;
    v[pcg_pkg::PCG_U_WDT] = r[pcg_pkg::PCG_WDT_BIT];
    v[pcg_pkg::PCG_U_HIB] = r[pcg_pkg::PCG_HIB_BIT];
    v[pcg_pkg::PCG_U_ADC] = r[pcg_pkg::PCG_ADC_BIT];
    v[pcg_pkg::PCG_U_PWM] = r[pcg_pkg::PCG_PWM_BIT];
    return v;
  endfunction : unit_bits

  wire logic auto_gate;
  wire logic [3:0] run_units;
  wire logic [3:0] sleep_units;
  wire logic [3:0] deep_units;
  wire logic [3:0] active_units;
  wire logic deep_active;
  assign auto_gate = run_clock_config_reg[pcg_pkg::PCG_AUTO_GATE_BIT];
  assign run_units = unit_bits(run_gating_reg);
  assign sleep_units = unit_bits(sleep_gating_reg);
  assign deep_units = unit_bits(deep_sleep_gating_reg);

  // The mode selector decides which set drives the unit clocks.
  pcg_gate_sel #(
    .WIDTH(4)
  ) u_gate_sel (
    .power_mode(power_mode),
    .auto_gate(auto_gate),
    .run_gate(run_units),
    .sleep_gate(sleep_units),
    .deep_gate(deep_units),
    .gate_out(active_units),
    .use_deep(deep_active)
  );

  // ==========================================================================
  // Converter rate.
  // The deep-sleep set has no rate field, so the run field serves there.
  wire logic [1:0] rate_field;
  wire logic [1:0] rate_clamped;
  assign rate_field = (!deep_active && auto_gate && power_mode == pcg_pkg::PCG_MODE_SLEEP)
    ? sleep_gating_reg[pcg_pkg::PCG_RATE_LSB +: 2]
    : run_gating_reg[pcg_pkg::PCG_RATE_LSB +: 2];
  assign rate_clamped = (rate_field > RATE_MAX) ? RATE_MAX : rate_field;

  // ==========================================================================
  // Access faults: a strobe to an unclocked unit faults in the next cycle.
  wire logic [3:0] fault_next;
  assign fault_next = unit_access & ~clk_en_reg;
  assign unit_fault = fault_reg;
  assign unit_clk_en = clk_en_reg;
  assign converter_rate = rate_reg;

  // Level interrupt while any unmasked fault flag stands.
  assign irq = |(int_stat_reg & int_mask_reg);

  // ==========================================================================
  // Bus pipeline state.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= wr_start;
      wr_addr_reg <= haddr;
      if (rd_start) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Gating registers; the hibernation gate alone comes out of reset set.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      run_gating_reg <= pcg_pkg::PCG_GATE_RST;
      sleep_gating_reg <= pcg_pkg::PCG_GATE_RST;
      deep_sleep_gating_reg <= pcg_pkg::PCG_GATE_RST;
      run_clock_config_reg <= pcg_pkg::PCG_RUN_CFG_RST;
    end else begin
      run_gating_reg <= run_gating_next;
      sleep_gating_reg <= sleep_gating_next;
      deep_sleep_gating_reg <= deep_sleep_gating_next;
      run_clock_config_reg <= run_clock_config_next;
    end
  end

  // Interrupt flags and mask.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      int_stat_reg <= pcg_pkg::PCG_INT_RST;
      int_mask_reg <= pcg_pkg::PCG_INT_RST;
    end else begin
      int_stat_reg <= int_stat_next;
      int_mask_reg <= int_mask_next;
    end
  end

  // Registered unit outputs; enables reset to the hibernation-only pattern.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      clk_en_reg <= 4'h2;
      fault_reg <= 4'h0;
      rate_reg <= 2'h0;
    end else begin
      clk_en_reg <= active_units;
      fault_reg <= fault_next;
      rate_reg <= rate_clamped;
    end
  end

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence s_acc_gated(int u);
    unit_access[u] && !clk_en_reg[u];
  endsequence

  property p_fault_on_gated(int u);
    s_acc_gated(u) |=> unit_fault[u];
  endproperty
  a_fault_on_gated_wdt: assert property (p_fault_on_gated(0))
    else $error("Access to gated watchdog did not fault.");
  a_fault_on_gated_pwm: assert property (p_fault_on_gated(3))
    else $error("Access to gated PWM did not fault.");

  property p_no_fault_when_clocked;
    |unit_fault |-> |($past(unit_access) & ~$past(clk_en_reg));
  endproperty
  a_no_fault_when_clocked: assert property (p_no_fault_when_clocked)
    else $error("Fault raised for a clocked unit.");

  property p_reset_values;
    @(posedge mclk) disable iff (1'b0)
    !resetn |=> (deep_sleep_gating_reg == 32'h0000_0040)
      && (run_gating_reg[3] == 1'b0) && clk_en_reg == 4'h2;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("Gating reset values are wrong.");

  property p_hib_reset_one;
    @(posedge mclk) disable iff (1'b0)
    !resetn ##1 resetn |-> run_gating_reg[6] && sleep_gating_reg[6];
  endproperty
  a_hib_reset_one: assert property (p_hib_reset_one)
    else $error("Hibernation gate not set after reset.");

  property p_rate_limit;
    converter_rate <= RATE_MAX;
  endproperty
  a_rate_limit: assert property (p_rate_limit)
    else $error("Converter rate above the supported maximum.");

  property p_rate_follows_run;
    (power_mode == 2'b00) [*2] |-> converter_rate ==
      ($past(run_gating_reg[9:8]) > RATE_MAX ? RATE_MAX : $past(run_gating_reg[9:8]));
  endproperty
  a_rate_follows_run: assert property (p_rate_follows_run)
    else $error("Converter rate does not follow the run field.");

  property p_reserved_zero;
    ((run_gating_reg & ~32'h0011_0348) == 32'h0)
      && ((deep_sleep_gating_reg & ~32'h0011_0048) == 32'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved gating bit is set.");

  property p_sleep_needs_auto;
    !run_clock_config_reg[0] |=> clk_en_reg == $past(run_units);
  endproperty
  a_sleep_needs_auto: assert property (p_sleep_needs_auto)
    else $error("Non-run set applied without automatic gating.");

  property p_deep_set_used;
    (run_clock_config_reg[0] && power_mode == 2'b11) |=> clk_en_reg == $past(deep_units);
  endproperty
  a_deep_set_used: assert property (p_deep_set_used)
    else $error("Deep-sleep set not applied in deep sleep.");

  property p_sleep_set_used;
    (run_clock_config_reg[0] && power_mode == 2'b01) |=> clk_en_reg == $past(sleep_units);
  endproperty
  a_sleep_set_used: assert property (p_sleep_set_used)
    else $error("Sleep set not applied in sleep.");

  property p_deep_write;
    wr_dslp |=> deep_sleep_gating_reg[20] == $past(hwdata[20])
      && deep_sleep_gating_reg[16] == $past(hwdata[16]);
  endproperty
  a_deep_write: assert property (p_deep_write)
    else $error("Deep-sleep PWM or converter gate not written.");

  // A rising interrupt needs a new masked-in fault or a fresh mask write one cycle before.
  property p_irq_level;
    $rose(irq) |-> $past((|(unit_fault & int_mask_reg)) || wr_mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Interrupt output disagrees with flags and mask.");

  property p_fault_sets_flag;
    unit_fault[2] |=> int_stat_reg[2];
  endproperty
  a_fault_sets_flag: assert property (p_fault_sets_flag)
    else $error("Fault did not set its status flag.");

  property p_gated_off_reset;
    @(posedge mclk) disable iff (1'b0)
    !resetn |=> !clk_en_reg[0] && !clk_en_reg[2] && !clk_en_reg[3];
  endproperty
  a_gated_off_reset: assert property (p_gated_off_reset)
    else $error("Unit clocked straight out of reset.");

endmodule : pcg_ctrl

// ==== verification/tb.sv ====
// Self-checking testbench for the peripheral clock gating controller.
`timescale 1ns/1ps
module tb;
  // ==========================================================================
  // Clock, reset and stimulus signals.
  localparam logic [1:0] MAX_RATE = 2'h2;
  logic mclk, resetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [11:0] haddr;
  logic [1:0] htrans, power_mode, converter_rate;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, seed;
  logic [3:0] unit_access, unit_fault, unit_clk_en;
  logic rd_chk, obs;
  logic [31:0] rd_q[$];
  logic [10:0] obs_q[$];
  int n_mismatch, num_checks;

  // The maximum rate is lowered below the top code so that the clamp is exercised.
  pcg_ctrl #(.RATE_MAX(MAX_RATE)) i_dut (.mclk(mclk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .power_mode(power_mode), .unit_access(unit_access), .unit_fault(unit_fault),
    .unit_clk_en(unit_clk_en), .converter_rate(converter_rate), .irq(irq));

  // With a single slave the bus ready is the slave's own ready.
  assign hready = hreadyout;

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ==========================================================================
  // Helpers.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0400_0007 : 32'h0);
  endfunction : lfsr

  function automatic logic [1:0] clamp(input logic [1:0] v);
    return (v > MAX_RATE) ? MAX_RATE : v;
  endfunction : clamp

  function automatic logic [3:0] gate_en(input logic [31:0] w);
    return {w[20], w[16], w[6], w[3]};
  endfunction : gate_en

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // Waits for an edge with ready high; the bound keeps a stuck slave from hanging us.
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    // A slave that never answers, or answers with an error, counts as a mismatch.
    num_checks++;
    if (hreadyout !== 1'b1 || hresp !== 1'b0) begin
      n_mismatch++;
      $display("mismatch at %0t: ready %b response %b", $time, hreadyout, hresp);
    end
  endtask : wait_rdy

  task automatic ahb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= pcg_pkg::PCG_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    if (wr) begin
      hwdata <= d;
    end else begin
      rd_q.push_back(d);
      rd_chk <= 1'b1;
    end
    wait_rdy();
    rd_chk <= 1'b0;
  endtask : ahb_xfer

  // Outputs settle one cycle after the register update, so two edges are allowed.
  task automatic chk_ports(input logic [3:0] fl, input logic [3:0] en, input logic [1:0] rt,
                           input logic iq);
    repeat (2) @(posedge mclk);
    obs_q.push_back({fl, en, rt, iq});
    obs <= 1'b1;
    @(posedge mclk);
    obs <= 1'b0;
  endtask : chk_ports

  task automatic cmp_rd(input logic [31:0] got);
    logic [31:0] e;
    num_checks++;
    e = (rd_q.size() > 0) ? rd_q.pop_front() : 32'hxxxx_xxxx;
    if (got !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: read %h expected %h", $time, got, e);
    end
  endtask : cmp_rd

  task automatic cmp_port(input logic [10:0] got);
    logic [10:0] e;
    num_checks++;
    e = (obs_q.size() > 0) ? obs_q.pop_front() : 11'hxxx;
    if (got !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: ports %h expected %h", $time, got, e);
    end
  endtask : cmp_port

  // ==========================================================================
  // Monitor: compares at the falling edge, where every output has settled.
  always @(negedge mclk) begin
    if (rd_chk) begin
      cmp_rd(hrdata);
    end
    if (obs) begin
      cmp_port({unit_fault, unit_clk_en, converter_rate, irq});
    end
  end

  // Watchdog: the sequence needs a few hundred cycles at most.
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    give_verdict();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    logic [31:0] r, s, d, c, w;
    logic [1:0] m;
    logic ag;
    n_mismatch = 0;
    num_checks = 0;
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    power_mode = pcg_pkg::PCG_MODE_RUN;
    unit_access = 4'h0;
    rd_chk = 1'b0;
    obs = 1'b0;
    seed = 32'h7d40b1de;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    // Reset values of every register and of the outputs.
    ahb_xfer(1'b0, pcg_pkg::PCG_RUN_CFG_OFF, 32'h0);
    ahb_xfer(1'b0, pcg_pkg::PCG_RUN_GATE_OFF, 32'h40);
    ahb_xfer(1'b0, pcg_pkg::PCG_SLP_GATE_OFF, 32'h40);
    ahb_xfer(1'b0, pcg_pkg::PCG_DSLP_GATE_OFF, 32'h40);
    ahb_xfer(1'b0, pcg_pkg::PCG_INT_STAT_OFF, 32'h0);
    ahb_xfer(1'b0, pcg_pkg::PCG_INT_MASK_OFF, 32'h0);
    chk_ports(4'h0, 4'b0010, 2'h0, 1'b0);
    // An unmapped place reads zero and ignores writes.
    ahb_xfer(1'b1, 12'h200, 32'hffff_ffff);
    ahb_xfer(1'b0, 12'h200, 32'h0);
    // Every rate code, clamped at the supported maximum.
    for (int v = 0; v < 4; v++) begin
      ahb_xfer(1'b1, pcg_pkg::PCG_RUN_GATE_OFF, 32'h48 | (v << 8));
      chk_ports(4'h0, 4'b0011, clamp(v[1:0]), 1'b0);
    end
    // Random gating sets, automatic gating and power modes.
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      r = seed;
      seed = lfsr(seed);
      s = seed;
      seed = lfsr(seed);
      d = seed;
      seed = lfsr(seed);
      c = seed;
      m = (i < 4) ? i[1:0] : seed[5:4];
      ag = c[0];
      ahb_xfer(1'b1, pcg_pkg::PCG_RUN_GATE_OFF, r);
      ahb_xfer(1'b1, pcg_pkg::PCG_SLP_GATE_OFF, s);
      ahb_xfer(1'b1, pcg_pkg::PCG_DSLP_GATE_OFF, d);
      ahb_xfer(1'b1, pcg_pkg::PCG_RUN_CFG_OFF, c);
      power_mode <= m;
      ahb_xfer(1'b0, pcg_pkg::PCG_RUN_GATE_OFF, r & pcg_pkg::PCG_RUN_SLP_MASK);
      ahb_xfer(1'b0, pcg_pkg::PCG_SLP_GATE_OFF, s & pcg_pkg::PCG_RUN_SLP_MASK);
      ahb_xfer(1'b0, pcg_pkg::PCG_DSLP_GATE_OFF, d & pcg_pkg::PCG_DSLP_MASK);
      ahb_xfer(1'b0, pcg_pkg::PCG_RUN_CFG_OFF, {31'h0, ag});
      w = (ag && m == pcg_pkg::PCG_MODE_SLEEP) ? s : (ag && m == pcg_pkg::PCG_MODE_DEEP) ? d : r;
      c[1:0] = (ag && m == pcg_pkg::PCG_MODE_SLEEP) ? s[9:8] : r[9:8];
      chk_ports(4'h0, gate_en(w), clamp(c[1:0]), 1'b0);
    end
    // Faults on unclocked units, status, mask and write-one-to-clear.
    ahb_xfer(1'b1, pcg_pkg::PCG_RUN_CFG_OFF, 32'h0);
    ahb_xfer(1'b1, pcg_pkg::PCG_RUN_GATE_OFF, 32'h0);
    power_mode <= pcg_pkg::PCG_MODE_RUN;
    chk_ports(4'h0, 4'h0, 2'h0, 1'b0);
    unit_access <= 4'hd;
    @(posedge mclk);
    unit_access <= 4'h0;
    obs_q.push_back({4'hd, 4'h0, 2'h0, 1'b0});
    obs <= 1'b1;
    @(posedge mclk);
    obs <= 1'b0;
    ahb_xfer(1'b0, pcg_pkg::PCG_INT_STAT_OFF, 32'hd);
    ahb_xfer(1'b1, pcg_pkg::PCG_INT_MASK_OFF, 32'h1);
    chk_ports(4'h0, 4'h0, 2'h0, 1'b1);
    ahb_xfer(1'b1, pcg_pkg::PCG_INT_STAT_OFF, 32'h1);
    ahb_xfer(1'b0, pcg_pkg::PCG_INT_STAT_OFF, 32'hc);
    chk_ports(4'h0, 4'h0, 2'h0, 1'b0);
    // A clocked watchdog is accessed without a fault.
    ahb_xfer(1'b1, pcg_pkg::PCG_RUN_GATE_OFF, 32'h8);
    chk_ports(4'h0, 4'h1, 2'h0, 1'b0);
    unit_access <= 4'h1;
    @(posedge mclk);
    unit_access <= 4'h0;
    obs_q.push_back({4'h0, 4'h1, 2'h0, 1'b0});
    obs <= 1'b1;
    @(posedge mclk);
    obs <= 1'b0;
    repeat (4) @(posedge mclk);
    give_verdict();
  end
endmodule : tb
